/* File: core/ioc_clkout.sv */
// Purpose: microcontroller clock output selection and division
// Assumes: crystal clock and 32 kHz clock arrive as sampled levels
// Notes:   output is registered, one reference cycle late
`timescale 1ns/1ps
`include "ioc_params.svh"

module ioc_clkout (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       xtal_clk_i,
    input  wire logic       xtal_run_i,
    input  wire logic       lf_clk_i,
    input  wire logic [1:0] sel_i,
    input  wire logic       lf_off_i,
    output logic            mcu_clk_o
);

    ioc_pkg::ioc_clk_t s_q;
    ioc_pkg::ioc_clk_t s_d;

    // ======================================================================
    // divider and selection
    always_comb begin
        s_d        = s_q;
        s_d.xtal_q = xtal_clk_i;
        if (xtal_clk_i && !s_q.xtal_q) begin
            s_d.div = s_q.div + 2'h1;
        end
        if (sel_i == `IOC_CLK_OFF) begin
            s_d.clk_out = 1'b0;
        end else if (!xtal_run_i) begin
            s_d.clk_out = lf_clk_i & ~lf_off_i;
        end else begin
            unique case (sel_i)
                `IOC_CLK_339:  s_d.clk_out = s_q.div[1];
                `IOC_CLK_678:  s_d.clk_out = s_q.div[0];
                default:       s_d.clk_out = xtal_clk_i;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign mcu_clk_o = s_q.clk_out;

endmodule

/* File: core/ioc_regs.sv */
// Purpose: io configuration register pair behind the serial port
// Assumes: serial pins sampled synchronously, rst_i is power-up reset
// Notes:   mosi sampled on sclk fall, miso shifts on sclk rise
`timescale 1ns/1ps
`include "ioc_params.svh"

module ioc_regs (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // serial port
    input  wire logic       ss_n_i,
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    output logic            miso_pd_o,
    output logic            miso_hi_drive_o,
    output logic            set_default_cmd_o,
    // clock sources
    input  wire logic       xtal_clk_i,
    input  wire logic       xtal_run_i,
    input  wire logic       lf_clk_i,
    output logic            mcu_clk_o,
    // antenna and fifo
    output logic            single_drive_o,
    output logic            second_driver_select_o,
    output logic [6:0]      rx_watermark_o,
    output logic [5:0]      tx_watermark_o,
    output logic            xtal_27m_o,
    // supply
    output logic            low_supply_mode_o,
    output logic            digital_supply_rail_off_o,
    // transmitter ramp
    input  wire logic       tx_on_i,
    output logic            slow_ramp_o,
    output logic [7:0]      tx_level_o
);

    localparam logic [2:0] RAMP_STEP = 3'(`IOC_RAMP_STEP_CYC);

    ioc_pkg::ioc_regs_t s_q;
    ioc_pkg::ioc_regs_t s_d;

    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] in_byte;

    // ======================================================================
    // register read decode
    function automatic logic [7:0] rd_reg(
        input logic [5:0] a,
        input logic [7:0] c1,
        input logic [7:0] c2
    );
        logic [7:0] v;
        v = 8'h00;
        if (a == `IOC_CFG1_ADDR) begin
            v = c1 & `IOC_CFG1_MASK;
        end else if (a == `IOC_CFG2_ADDR) begin
            v = c2 & `IOC_CFG2_MASK;
        end
        return v;
    endfunction

    // ======================================================================
    // serial edges
    assign sclk_rise = sclk_i & ~s_q.sclk_q;
    assign sclk_fall = ~sclk_i & s_q.sclk_q;
    assign in_byte   = {s_q.in_sh[6:0], mosi_i};

    // ======================================================================
    // next state
    always_comb begin
        s_d        = s_q;
        s_d.sclk_q = sclk_i;
        s_d.setdef = 1'b0;

        if (ss_n_i) begin
            s_d.st      = ioc_pkg::ST_CMD;
            s_d.bit_cnt = 3'h0;
            s_d.miso_oe = 1'b0;
        end else begin
            // next read bit shown after the byte's first bit
            if (sclk_rise && s_q.bit_cnt != 3'h0) begin
                s_d.out_sh = {s_q.out_sh[6:0], 1'b0};
            end
            if (sclk_fall) begin
                s_d.in_sh = in_byte;
                if (s_q.bit_cnt == 3'h7) begin
                    s_d.bit_cnt = 3'h0;
                    unique case (s_q.st)
                        ioc_pkg::ST_CMD: begin
                            s_d.addr = in_byte[5:0];
                            if (in_byte[7:6] == `IOC_OP_WRITE) begin
                                s_d.st = ioc_pkg::ST_WR;
                            end else if (in_byte[7:6] == `IOC_OP_READ) begin
                                s_d.st      = ioc_pkg::ST_RD;
                                s_d.out_sh  = rd_reg(in_byte[5:0], s_q.cfg1, s_q.cfg2);
                                s_d.miso_oe = 1'b1;
                            end else begin
                                // direct command: config pair is not touched
                                s_d.setdef = (in_byte[7:6] == `IOC_OP_CMD) &&
                                             (in_byte[5:0] == `IOC_CMD_SET_DEFAULT);
                                s_d.st     = ioc_pkg::ST_SKIP;
                            end
                        end
                        ioc_pkg::ST_WR: begin
                            if (s_q.addr == `IOC_CFG1_ADDR) begin
                                s_d.cfg1 = in_byte & `IOC_CFG1_MASK;
                            end else if (s_q.addr == `IOC_CFG2_ADDR) begin
                                s_d.cfg2 = in_byte & `IOC_CFG2_MASK;
                            end
                            s_d.addr = s_q.addr + 6'h01;
                        end
                        ioc_pkg::ST_RD: begin
                            s_d.addr   = s_q.addr + 6'h01;
                            s_d.out_sh = rd_reg(s_q.addr + 6'h01, s_q.cfg1, s_q.cfg2);
                        end
                        ioc_pkg::ST_SKIP: begin
                            s_d.st = ioc_pkg::ST_SKIP;
                        end
                    endcase
                end else begin
                    s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                end
            end
        end

        // transmitter switch-on ramp
        if (!tx_on_i) begin
            s_d.ramp_lvl = 8'h00;
            s_d.ramp_cnt = 3'h0;
        end else if (!s_q.cfg2[`IOC_SLOW_BIT]) begin
            s_d.ramp_lvl = 8'hff;
        end else if (s_q.ramp_lvl != 8'hff) begin
            if (s_q.ramp_cnt == RAMP_STEP - 3'h1) begin
                s_d.ramp_cnt = 3'h0;
                s_d.ramp_lvl = s_q.ramp_lvl + 8'h01;
            end else begin
                s_d.ramp_cnt = s_q.ramp_cnt + 3'h1;
            end
        end
    end

    // ======================================================================
    // state register, power-up reset only
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.st       <= ioc_pkg::ST_CMD;
            s_q.sclk_q   <= 1'b0;
            s_q.cfg1     <= `IOC_CFG1_RST;
            s_q.cfg2     <= `IOC_CFG2_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // serial pin outputs
    assign miso_oe_o         = s_q.miso_oe & ~ss_n_i;
    assign miso_o            = s_q.out_sh[7] & miso_oe_o;
    assign miso_pd_o         = (ss_n_i & s_q.cfg2[`IOC_IDLE_PD_BIT]) |
                               (~ss_n_i & ~miso_oe_o & s_q.cfg2[`IOC_SEL_PD_BIT]);
    assign miso_hi_drive_o   = s_q.cfg2[`IOC_HI_DRV_BIT];
    assign set_default_cmd_o = s_q.setdef;

    // ======================================================================
    // configuration outputs
    assign single_drive_o         = s_q.cfg1[`IOC_SINGLE_BIT];
    assign second_driver_select_o = s_q.cfg1[`IOC_SINGLE_BIT] &
                                    s_q.cfg1[`IOC_DRV_B_BIT];
    assign rx_watermark_o = s_q.cfg1[`IOC_RXWL_BIT] ? `IOC_RX_WL_HI : `IOC_RX_WL_LO;
    assign tx_watermark_o = s_q.cfg1[`IOC_TXWL_BIT] ? `IOC_TX_WL_HI : `IOC_TX_WL_LO;
    assign xtal_27m_o                = s_q.cfg1[`IOC_XTAL_BIT];
    assign low_supply_mode_o         = s_q.cfg2[`IOC_LOW_SUP_BIT];
    assign digital_supply_rail_off_o = s_q.cfg2[`IOC_REG_OFF_BIT];
    assign slow_ramp_o               = s_q.cfg2[`IOC_SLOW_BIT];
    assign tx_level_o                = s_q.ramp_lvl;

    // ======================================================================
    // microcontroller clock output
    ioc_clkout u_clkout (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .xtal_clk_i (xtal_clk_i),
        .xtal_run_i (xtal_run_i),
        .lf_clk_i   (lf_clk_i),
        .sel_i      ({s_q.cfg1[`IOC_CLKSEL_HI_BIT], s_q.cfg1[`IOC_CLKSEL_LO_BIT]}),
        .lf_off_i   (s_q.cfg1[`IOC_LF_OFF_BIT]),
        .mcu_clk_o  (mcu_clk_o)
    );

endmodule

/* File: pkg/ioc_params.svh */
// Purpose: constants of the io configuration register pair
// Assumes: 125 MHz reference clock, 6-bit serial register addresses
// Notes:   offsets, field positions, reset values and timing counts
//
// How it works
// - cfg1 bit 7 high drives one antenna output, low drives both differentially.
// - cfg1 bit 6 picks driver a or driver b when driving single.
// - rx watermark select gives threshold 64 when low, 80 when high.
// - tx watermark select gives threshold 32 when low, 16 when high.
// - crystal select: 0 means 13.56 MHz, 1 means 27.12 MHz; defaults 1.
// - clock field 00/01/10 gives crystal/4, /2, /1 while crystal runs: 3.39/6.78/13.56 MHz with a 13.56 MHz crystal.
// - clock field 11 holds the microcontroller clock output low.
// - crystal stopped and output enabled: 32 kHz clock unless suppressed.
// - both registers take their defaults only at power-up reset.
// - cfg2 bit 7: low means 5 V supply, high means 3.3 V supply.
// - regulator-off bit disables digital supply regulator; resets to zero.
// - selected pull-down: pull MISO down while select low and undriven.
// - idle pull-down: pull MISO down whenever select is high.
// - low-voltage drive bit raises MISO drive strength for 1.8 V.
// - slow-ramp bit ramps transmitter so 10 to 90 percent takes at least 10 us.
// - set-default direct command leaves both registers untouched.
// - both registers read and written over the serial port at 6-bit addresses.
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH

// ==========================================================================
// register map
`define IOC_ADDR_W            6
`define IOC_CFG1_ADDR         6'h00
`define IOC_CFG2_ADDR         6'h01
`define IOC_CFG1_RST          8'h08
`define IOC_CFG2_RST          8'h00
`define IOC_CFG1_MASK         8'hff
`define IOC_CFG2_MASK         8'hdd

// ==========================================================================
// cfg1 fields
`define IOC_SINGLE_BIT        7
`define IOC_DRV_B_BIT         6
`define IOC_RXWL_BIT          5
`define IOC_TXWL_BIT          4
`define IOC_XTAL_BIT          3
`define IOC_CLKSEL_HI_BIT     2
`define IOC_CLKSEL_LO_BIT     1
`define IOC_LF_OFF_BIT        0

// ==========================================================================
// cfg2 fields
`define IOC_LOW_SUP_BIT       7
`define IOC_REG_OFF_BIT       6
`define IOC_SEL_PD_BIT        4
`define IOC_IDLE_PD_BIT       3
`define IOC_HI_DRV_BIT        2
`define IOC_SLOW_BIT          0

// ==========================================================================
// watermark levels, clock codes, serial command codes
`define IOC_RX_WL_LO          7'h40
`define IOC_RX_WL_HI          7'h50
`define IOC_TX_WL_LO          6'h20
`define IOC_TX_WL_HI          6'h10
`define IOC_CLK_339           2'h0
`define IOC_CLK_678           2'h1
`define IOC_CLK_1356          2'h2
`define IOC_CLK_OFF           2'h3
`define IOC_OP_WRITE          2'h0
`define IOC_OP_READ           2'h1
`define IOC_OP_CMD            2'h3
`define IOC_CMD_SET_DEFAULT   6'h01

// ==========================================================================
// timing
`define IOC_CLK_NS            8
`define IOC_RAMP_MIN_NS       10000
`define IOC_RAMP_STEPS_1090   204
`define IOC_RAMP_STEP_CYC     ((`IOC_RAMP_MIN_NS + `IOC_CLK_NS * `IOC_RAMP_STEPS_1090 - 1) / (`IOC_CLK_NS * `IOC_RAMP_STEPS_1090))

`endif

/* File: pkg/ioc_pkg.sv */
// Purpose: types of the io configuration register pair
// Assumes: constants come from ioc_params.svh
// Notes:   one-hot serial states, packed state records
package ioc_pkg;

    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD   = 4'b0100,
        ST_SKIP = 4'b1000
    } ioc_state_t;

    typedef struct packed {
        ioc_state_t  st;
        logic        sclk_q;
        logic [2:0]  bit_cnt;
        logic [7:0]  in_sh;
        logic [7:0]  out_sh;
        logic        miso_oe;
        logic [5:0]  addr;
        logic [7:0]  cfg1;
        logic [7:0]  cfg2;
        logic        setdef;
        logic [2:0]  ramp_cnt;
        logic [7:0]  ramp_lvl;
    } ioc_regs_t;

    typedef struct packed {
        logic        xtal_q;
        logic [1:0]  div;
        logic        clk_out;
    } ioc_clk_t;

endpackage

/* File: testbench/ioc_host_model.sv */
// Purpose: host microcontroller on the serial port
// Assumes: sclk high for 3 and low for 4 reference cycles, cpol0 cpha1
// Notes:   mosi flips when deselected so stale data never looks valid
`timescale 1ns/1ps
module ioc_host_model (
    input  wire logic ref_clk_i,
    input  wire logic miso_i,
    output logic      ss_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    initial begin
        ss_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // ==========================================================
    // framing and byte transfer
    task automatic select(input logic on);
        @(posedge ref_clk_i);
        ss_n_o <= !on;
        if (!on) mosi_o <= !mosi_o;
        repeat (3) @(posedge ref_clk_i);
    endtask
    // msb first, miso taken just before each fall, after the rise has shifted it
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            mosi_o <= tx[b];
            repeat (2) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            rx[b] = miso_i;
            @(posedge ref_clk_i);
            sclk_o <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
endmodule

/* File: testbench/ioc_regs_checker.sv */
// Purpose: port-level checks of ioc_regs
// Assumes: one clock, rst_i synchronous active high
// Notes:   bound to ioc_regs from the testbench top
`timescale 1ns/1ps
module ioc_regs_checker (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ss_n_i,
    input  wire logic       tx_on_i,
    input  wire logic       miso_o,
    input  wire logic       miso_oe_o,
    input  wire logic       miso_pd_o,
    input  wire logic       set_default_cmd_o,
    input  wire logic       single_drive_o,
    input  wire logic       second_driver_select_o,
    input  wire logic [6:0] rx_watermark_o,
    input  wire logic [5:0] tx_watermark_o,
    input  wire logic       xtal_27m_o,
    input  wire logic       slow_ramp_o,
    input  wire logic [7:0] tx_level_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // assertions
    AST_RST_VAL: assert property ($past(rst_i) |-> xtal_27m_o && !single_drive_o
        && rx_watermark_o == 7'h40 && tx_watermark_o == 6'h20 && !slow_ramp_o)
        else $error("config outputs not at power-up values");
    AST_RX_LEVEL: assert property (rx_watermark_o == 7'h40 || rx_watermark_o == 7'h50)
        else $error("rx level illegal");
    AST_TX_LEVEL: assert property (tx_watermark_o inside {6'h20, 6'h10})
        else $error("tx level illegal");
    AST_DIFF_DRV: assert property (!single_drive_o |-> !second_driver_select_o)
        else $error("driver select in differential mode");
    AST_OE_SEL: assert property (ss_n_i |-> !miso_oe_o && !miso_o)
        else $error("miso driven while deselected");
    AST_PD_DRIVEN: assert property (miso_oe_o |-> !miso_pd_o)
        else $error("pull-down while driving");
    AST_SETDEF_HOLD: assert property (set_default_cmd_o |=> !set_default_cmd_o
        && $stable(xtal_27m_o) && $stable(rx_watermark_o) && $stable(single_drive_o))
        else $error("set default touched config");
    AST_RAMP_OFF: assert property (!tx_on_i |=> tx_level_o == 8'h00)
        else $error("level not zero with tx off");
    AST_RAMP_FAST: assert property (tx_on_i && !slow_ramp_o |=> tx_level_o == 8'hff)
        else $error("fast ramp not immediate");
    AST_RAMP_STEP: assert property (tx_on_i && slow_ramp_o |=>
        tx_level_o == $past(tx_level_o) || tx_level_o == $past(tx_level_o) + 8'h01)
        else $error("slow ramp step too large");
    AST_CFG_QUIET: assert property ($past(ss_n_i) && !$past(rst_i) |->
        $stable(rx_watermark_o) && $stable(tx_watermark_o) && $stable(single_drive_o)
        && $stable(xtal_27m_o) && $stable(slow_ramp_o))
        else $error("config changed while deselected");
endmodule

/* File: testbench/test_ioc_regs.sv */
// Purpose: self-checking bench of ioc_regs
// Assumes: 125 MHz clock, host model on the serial port
// Notes:   crystal and slow clock made here at 1/8 and 1/32 of the reference rate
`timescale 1ns/1ps
module test_ioc_regs;
    logic       ref_clk_i, rst_i, ss_n_i, sclk_i, mosi_i, miso_w, tx_on_i;
    logic       xtal_clk_i, xtal_run_i, lf_clk_i, mcu_clk_o, set_default_cmd_o;
    logic       miso_o, miso_oe_o, miso_pd_o, miso_hi_drive_o, slow_ramp_o;
    logic       single_drive_o, second_driver_select_o, xtal_27m_o;
    logic       low_supply_mode_o, digital_supply_rail_off_o;
    logic [6:0] rx_watermark_o;
    logic [5:0] tx_watermark_o;
    logic [7:0] tx_level_o, rd_q;
    logic [4:0] div_q = 5'h00;
    logic [7:0] cfg_tab[3] = '{8'hf6, 8'h40, 8'h91};
    int         clk_tab[7][3] = '{'{1,0,8}, '{1,2,16}, '{1,4,32}, '{1,6,0}, '{0,0,8},
                                  '{0,1,0}, '{0,6,0}};
    int         errors, compares, setdef_cnt;

    ioc_regs u_dut (
        .ref_clk_i                 (ref_clk_i),
        .rst_i                     (rst_i),
        .ss_n_i                    (ss_n_i),
        .sclk_i                    (sclk_i),
        .mosi_i                    (mosi_i),
        .miso_o                    (miso_o),
        .miso_oe_o                 (miso_oe_o),
        .miso_pd_o                 (miso_pd_o),
        .miso_hi_drive_o           (miso_hi_drive_o),
        .set_default_cmd_o         (set_default_cmd_o),
        .xtal_clk_i                (xtal_clk_i),
        .xtal_run_i                (xtal_run_i),
        .lf_clk_i                  (lf_clk_i),
        .mcu_clk_o                 (mcu_clk_o),
        .single_drive_o            (single_drive_o),
        .second_driver_select_o    (second_driver_select_o),
        .rx_watermark_o            (rx_watermark_o),
        .tx_watermark_o            (tx_watermark_o),
        .xtal_27m_o                (xtal_27m_o),
        .low_supply_mode_o         (low_supply_mode_o),
        .digital_supply_rail_off_o (digital_supply_rail_off_o),
        .tx_on_i                   (tx_on_i),
        .slow_ramp_o               (slow_ramp_o),
        .tx_level_o                (tx_level_o)
    );
    ioc_host_model u_host (.ref_clk_i(ref_clk_i), .miso_i(miso_w), .ss_n_o(ss_n_i),
                           .sclk_o(sclk_i), .mosi_o(mosi_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) div_q <= div_q + 5'h01;
    always @(negedge ref_clk_i) setdef_cnt += set_default_cmd_o;
    assign xtal_clk_i = div_q[2];
    assign lf_clk_i   = div_q[4];
    assign miso_w     = miso_oe_o ? miso_o : (miso_pd_o ? 1'b0 : div_q[0]);

    // ==========================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        u_host.select(1'b1);
        u_host.xfer(c, r);
        u_host.xfer(d, rd_q);
        u_host.select(1'b0);
    endtask
    task automatic count_mcu(output int n);
        logic p;
        n = 0;
        p = mcu_clk_o;
        repeat (256) begin
            @(negedge ref_clk_i);
            n += (mcu_clk_o && !p);
            p = mcu_clk_o;
        end
    endtask
    task automatic report_and_stop;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        int n;
        logic [7:0] v;
        rst_i = 1'b1;
        tx_on_i = 1'b0;
        xtal_run_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({single_drive_o, second_driver_select_o, xtal_27m_o, low_supply_mode_o,
             digital_supply_rail_off_o, miso_hi_drive_o, slow_ramp_o, 1'b0}, 8'h20);
        acc(8'h40, 8'h00);
        chk(rd_q, 8'h08);
        foreach (cfg_tab[i]) begin
            v = cfg_tab[i];
            acc(8'h00, v);
            acc(8'h40, 8'h00);
            chk(rd_q, v);
            chk({single_drive_o, second_driver_select_o, xtal_27m_o}, {v[7], v[7] & v[6], v[3]});
            chk({1'b0, rx_watermark_o}, v[5] ? 8'h50 : 8'h40);
            chk({2'h0, tx_watermark_o}, v[4] ? 8'h10 : 8'h20);
        end
        foreach (clk_tab[i]) begin
            @(posedge ref_clk_i);
            xtal_run_i <= clk_tab[i][0][0];
            acc(8'h00, clk_tab[i][1][7:0]);
            repeat (40) @(posedge ref_clk_i);
            count_mcu(n);
            v = clk_tab[i][2][7:0];
            chk({7'h0, n >= v - (v != 0) && n <= v + (v != 0)}, 8'h01);
        end
        acc(8'h01, 8'hff);
        acc(8'h41, 8'h00);
        chk(rd_q, 8'hdd);
        chk({low_supply_mode_o, digital_supply_rail_off_o, miso_hi_drive_o, slow_ramp_o,
             miso_pd_o, 3'h0}, 8'hf8);
        for (int i = 0; i < 2; i++) begin
            acc(8'h01, i ? 8'h08 : 8'h10);
            chk({7'h0, miso_pd_o}, i ? 8'h01 : 8'h00);
            u_host.select(1'b1);
            chk({7'h0, miso_pd_o}, i ? 8'h00 : 8'h01);
            u_host.select(1'b0);
        end
        acc(8'h05, 8'h5a);
        acc(8'h45, 8'h00);
        chk(rd_q, 8'h00);
        acc(8'hc1, 8'hff);
        acc(8'h80, 8'hff);
        acc(8'h41, 8'h00);
        chk(rd_q, 8'h08);
        acc(8'h40, 8'h00);
        chk(rd_q, 8'h06);
        chk(setdef_cnt[7:0], 8'h01);
        acc(8'h01, 8'h01);
        tx_on_i <= 1'b1;
        n = 0;
        repeat (2500) begin
            @(negedge ref_clk_i);
            n += (tx_level_o > 8'h1a && tx_level_o < 8'he6);
        end
        chk({7'h0, n >= 1250 && tx_level_o == 8'hff}, 8'h01);
        @(posedge ref_clk_i);
        tx_on_i <= 1'b0;
        repeat (2) @(negedge ref_clk_i);
        chk(tx_level_o, 8'h00);
        acc(8'h01, 8'h00);
        tx_on_i <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        chk(tx_level_o, 8'hff);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        acc(8'h40, 8'h00);
        chk(rd_q, 8'h08);
        report_and_stop();
    end
endmodule

bind ioc_regs ioc_regs_checker u_chk (
    .ref_clk_i              (ref_clk_i),
    .rst_i                  (rst_i),
    .ss_n_i                 (ss_n_i),
    .tx_on_i                (tx_on_i),
    .miso_o                 (miso_o),
    .miso_oe_o              (miso_oe_o),
    .miso_pd_o              (miso_pd_o),
    .set_default_cmd_o      (set_default_cmd_o),
    .single_drive_o         (single_drive_o),
    .second_driver_select_o (second_driver_select_o),
    .rx_watermark_o         (rx_watermark_o),
    .tx_watermark_o         (tx_watermark_o),
    .xtal_27m_o             (xtal_27m_o),
    .slow_ramp_o            (slow_ramp_o),
    .tx_level_o             (tx_level_o)
);
